// [rtl/pau_defines.svh]
// Purpose: constants of the process alarm unit
// Assumes: 125 MHz ref_clk, one evaluation tick per filtered sample
// Notes:   offsets are word indices on the plain register port
`ifndef PAU_DEFINES_SVH
`define PAU_DEFINES_SVH
`define PAU_DW          16
`define PAU_AW          4
`define PAU_CLK_KHZ     125000
`define PAU_SAMPLE_MS   100
`define PAU_SPAN        3000
// filter time constants in ms
`define PAU_TAU_1_MS    400
`define PAU_TAU_2_MS    1000
`define PAU_TAU_3_MS    2000
`define PAU_TAU_4_MS    3000
`define PAU_TAU_5_MS    4000
`define PAU_TAU_6_MS    5000
// register map
`define PAU_ADDR_CTRL   4'h0
`define PAU_ADDR_SP     4'h1
`define PAU_ADDR_STAT   4'h2
`define PAU_SUB_CFG     2'h0
`define PAU_SUB_THR     2'h1
`define PAU_SUB_HYST    2'h2
// fields
`define PAU_CTRL_CFGLVL 0
`define PAU_CTRL_RESTORE 1
`define PAU_STAT_ALARM  0
`define PAU_STAT_COND   3
`define PAU_STAT_MASK   6
`define PAU_STAT_RELAY  9
// reset values
`define PAU_CFG_RST     9'h020
`define PAU_THR_RST     16'h0000
`define PAU_HYST_RST    16'h001E
`define PAU_SP_RST      16'h0000
`endif

// [rtl/pau_pkg.sv]
// Purpose: types of the process alarm unit
// Assumes: pau_defines.svh on the include path
// Notes:   none
`include "pau_defines.svh"
package pau_pkg;
    typedef enum logic [1:0] {
        TYP_OFF       = 2'b00,
        TYP_PROCESS   = 2'b01,
        TYP_DEVIATION = 2'b11,
        TYP_BAND      = 2'b10
    } pau_type_e;
    typedef enum logic [1:0] {
        SNS_HIGH        = 2'b00,
        SNS_LOW         = 2'b01,
        SNS_LOW_INHIBIT = 2'b11
    } pau_sense_e;
    typedef struct packed {
        logic [2:0] filterSel;
        logic       polarity;
        logic       latching;
        pau_sense_e sense;
        pau_type_e  kind;
    } pau_cfg_s;
    typedef struct packed {
        pau_cfg_s [2:0]              cfg;
        logic [2:0][`PAU_DW-1:0]     thr;
        logic [2:0][`PAU_DW-1:0]     hyst;
        logic [`PAU_DW-1:0]          setpoint;
        logic                        configLevel;
        logic                        restorePend;
        logic                        spChgPend;
        logic [2:0]                  cond;
        logic [2:0]                  mask;
        logic [2:0]                  alarm;
        logic [2:0]                  ackPend;
        logic [2:0]                  relay;
        logic [2:0]                  led;
        logic                        beacon;
        logic [31:0]                 rdata;
    } pau_top_s;
    typedef struct packed {
        logic signed [`PAU_DW+7:0] acc;
        logic                      done;
    } pau_filt_s;
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } pau_div_s;
endpackage : pau_pkg

// [rtl/pau_divider.sv]
// Purpose: sample tick divider
// Assumes: CYCLES of at least two
// Notes:   one-cycle tick every CYCLES clocks
`timescale 1ns/1ps
`include "pau_defines.svh"
module pau_divider #(
    parameter int unsigned CYCLES = `PAU_SAMPLE_MS * `PAU_CLK_KHZ
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // tick
    output logic      tickOut
);
    pau_pkg::pau_div_s s_r;
    pau_pkg::pau_div_s s_nxt;

    initial
    begin
        if (CYCLES < 2)
            $error("pau_divider: CYCLES must be at least 2");
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == CYCLES - 1)
        begin
            s_nxt.cnt = 32'h0000_0000;
            s_nxt.tick = 1'b1;
        end
        else
            s_nxt.cnt = s_r.cnt + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tickOut = s_r.tick;
endmodule : pau_divider

// [rtl/pau_filter.sv]
// Purpose: first-order alarm input filter
// Assumes: one update per sample tick
// Notes:   eight fraction bits keep small steps from stalling
`timescale 1ns/1ps
`include "pau_defines.svh"
module pau_filter #(
    parameter int unsigned DW        = `PAU_DW,
    parameter int unsigned SAMPLE_MS = `PAU_SAMPLE_MS
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          srst,
    // sample
    input  wire logic          tickIn,
    input  wire logic [2:0]    sel,
    input  wire logic [DW-1:0] din,
    output logic      [DW-1:0] dout,
    output logic               doneOut
);
    localparam int AW = DW + 8;
    pau_pkg::pau_filt_s s_r;
    pau_pkg::pau_filt_s s_nxt;
    logic signed [AW:0]   diff;
    logic signed [AW+9:0] prod;
    logic [7:0]           k;

    initial
    begin
        if (DW != `PAU_DW || SAMPLE_MS >= `PAU_TAU_1_MS)
            $error("pau_filter: unsupported DW or SAMPLE_MS");
    end

    // gain per tick is sample period over time constant
    function automatic logic [7:0] coefOf(input logic [2:0] f);
        int tau;
        case (f)
            3'd1:    tau = `PAU_TAU_1_MS;
            3'd2:    tau = `PAU_TAU_2_MS;
            3'd3:    tau = `PAU_TAU_3_MS;
            3'd4:    tau = `PAU_TAU_4_MS;
            3'd5:    tau = `PAU_TAU_5_MS;
            3'd6:    tau = `PAU_TAU_6_MS;
            default: tau = 0;
        endcase
        return (tau == 0) ? 8'h00 : 8'((256 * SAMPLE_MS) / tau);
    endfunction : coefOf

    always_comb
    begin
        s_nxt = s_r;
        k = coefOf(sel);
        diff = $signed({din[DW-1], din, 8'h00}) -
               $signed({s_r.acc[AW-1], s_r.acc});
        prod = diff * $signed({1'b0, k});
        s_nxt.done = tickIn;
        if (tickIn)
        begin
            if (k == 8'h00)
                s_nxt.acc = $signed({din, 8'h00});
            else
                s_nxt.acc = s_r.acc + prod[AW+7:8];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign dout    = s_r.acc[AW-1:8];
    assign doneOut = s_r.done;
endmodule : pau_filter

// [rtl/pau_process_alarm_unit.sv]
// Purpose: three process alarm channels with relay drives
// Assumes: inputs synchronous to ref_clk; signed process values
// Notes:   channel state updates only on a filtered sample
`timescale 1ns/1ps
`include "pau_defines.svh"
// Function
// - three channels, each off, absolute, deviation or band type
// - sense is high, low, or low inhibited at start-up
// - reset behaviour per channel is automatic or latching
// - process high sets above threshold, clears below it minus hysteresis
// - process low sets below threshold, clears above it plus hysteresis
// - band high sets outside setpoint window, clears hysteresis inside
// - band low sets inside setpoint window, clears hysteresis outside
// - deviation high sets above setpoint plus threshold, hysteresis clear
// - deviation low sets below setpoint plus threshold, hysteresis clear
// - start-up mask holds alarm off until process first reaches safety
// - the mask restore command re-arms the start-up mask
// - deviation and band masks re-arm on setpoint change or ramp
// - automatic alarms clear as soon as the condition goes
// - latched alarms need condition gone and an acknowledge
// - acknowledge while the condition persists is ignored
// - failsafe relay of an enabled channel is energised while no alarm is present
// - non-failsafe relay of an enabled channel is energised only while alarm is active
// - every relay polarity resets to failsafe
// - alarms keep working in both auto and manual control
// - any active alarm lights its number and the common beacon
// - hysteresis limited to 0.1 to 10 percent span, at least 1 digit
// - optional input filter: off, 0.4, 1, 2, 3, 4 or 5 seconds
// - configuration level gives no alarm indication; alarms and relays hold their state
module pau_process_alarm_unit #(
    parameter int unsigned DW            = `PAU_DW,
    parameter int unsigned SPAN          = `PAU_SPAN,
    parameter int unsigned SAMPLE_CYCLES = `PAU_SAMPLE_MS * `PAU_CLK_KHZ
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // register port
    input  wire logic [`PAU_AW-1:0]   regAddr,
    input  wire logic [31:0]          regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic      [31:0]          regRdata,
    // process side
    input  wire logic [DW-1:0]        processValue,
    input  wire logic                 setpointRamp,
    input  wire logic                 ackContact,
    // relays and indicators
    output logic      [2:0]           relayDrive,
    output logic      [2:0]           alarmLed,
    output logic                      alarmBeacon
);
    localparam int XW = DW + 2;
    pau_pkg::pau_top_s s_r;
    pau_pkg::pau_top_s s_nxt;
    logic [2:0][DW-1:0] filt;
    logic [2:0]         fDone;
    logic               tick;

    initial
    begin
        if (DW != `PAU_DW || SPAN < 10)
            $error("pau_process_alarm_unit: unsupported DW or SPAN");
    end

    pau_divider #(
        .CYCLES (SAMPLE_CYCLES)
    ) u_div (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tickOut (tick)
    );

    for (genvar g = 0; g < 3; g++)
    begin : g_filt
        pau_filter #(
            .DW (DW)
        ) u_filt (
            .ref_clk (ref_clk),
            .srst    (srst),
            .tickIn  (tick),
            .sel     (s_r.cfg[g].filterSel),
            .din     (processValue),
            .dout    (filt[g]),
            .doneOut (fDone[g])
        );
    end

    function automatic logic signed [XW-1:0] sx(input logic [DW-1:0] v);
        return XW'($signed(v));
    endfunction : sx

    // channel index from address; 3 means not a channel
    function automatic logic [1:0] chanOf(input logic [`PAU_AW-1:0] a);
        return (a[3:2] == 2'd0) ? 2'd3 : a[3:2] - 2'd1;
    endfunction : chanOf

    function automatic logic [DW-1:0] clampHyst(input logic [DW-1:0] h);
        logic [DW-1:0] lo;
        logic [DW-1:0] hi;
        lo = (SPAN / 1000 > 1) ? DW'(SPAN / 1000) : DW'(1);
        hi = DW'(SPAN / 10);
        if (h < lo)
            return lo;
        else if (h > hi)
            return hi;
        else
            return h;
    endfunction : clampHyst

    always_comb
    begin
        logic signed [XW-1:0] f;
        logic signed [XW-1:0] sp;
        logic signed [XW-1:0] th;
        logic signed [XW-1:0] hy;
        logic signed [XW-1:0] ref0;
        logic                 hiSense;
        logic                 setC;
        logic                 clrC;
        logic                 ackEff;
        logic                 rearm;
        logic [1:0]           ch;
        f = '0;
        sp = '0;
        th = '0;
        hy = '0;
        ref0 = '0;
        hiSense = 1'b0;
        setC = 1'b0;
        clrC = 1'b0;
        ackEff = 1'b0;
        rearm = 1'b0;
        ch = chanOf(regAddr);
        s_nxt = s_r;
        s_nxt.rdata = 32'h0000_0000;
        // register writes
        if (regWr)
        begin
            if (regAddr == `PAU_ADDR_CTRL)
            begin
                s_nxt.configLevel = regWdata[`PAU_CTRL_CFGLVL];
                if (regWdata[`PAU_CTRL_RESTORE])
                    s_nxt.restorePend = 1'b1;
            end
            else if (regAddr == `PAU_ADDR_SP)
            begin
                s_nxt.setpoint = regWdata[DW-1:0];
                if (regWdata[DW-1:0] != s_r.setpoint)
                    s_nxt.spChgPend = 1'b1;
            end
            else if (ch != 2'd3)
            begin
                unique case (regAddr[1:0])
                    `PAU_SUB_CFG:
                        s_nxt.cfg[ch] = regWdata[8:0];
                    `PAU_SUB_THR:
                        s_nxt.thr[ch] = regWdata[DW-1:0];
                    `PAU_SUB_HYST:
                        s_nxt.hyst[ch] = clampHyst(regWdata[DW-1:0]);
                    default:
                        s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
        // register reads, answered in the next cycle
        if (regRd)
        begin
            if (regAddr == `PAU_ADDR_CTRL)
                s_nxt.rdata[`PAU_CTRL_CFGLVL] = s_r.configLevel;
            else if (regAddr == `PAU_ADDR_SP)
                s_nxt.rdata[DW-1:0] = s_r.setpoint;
            else if (regAddr == `PAU_ADDR_STAT)
            begin
                s_nxt.rdata[`PAU_STAT_ALARM +: 3] = s_r.alarm;
                s_nxt.rdata[`PAU_STAT_COND +: 3]  = s_r.cond;
                s_nxt.rdata[`PAU_STAT_MASK +: 3]  = s_r.mask;
                s_nxt.rdata[`PAU_STAT_RELAY +: 3] = s_r.relay;
            end
            else if (ch != 2'd3)
            begin
                unique case (regAddr[1:0])
                    `PAU_SUB_CFG:  s_nxt.rdata[8:0] = s_r.cfg[ch];
                    `PAU_SUB_THR:  s_nxt.rdata[DW-1:0] = s_r.thr[ch];
                    `PAU_SUB_HYST: s_nxt.rdata[DW-1:0] = s_r.hyst[ch];
                    default:       s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
        // channel evaluation; auto/manual mode is not an input here
        for (int i = 0; i < 3; i++)
        begin
            // contact only counts once the condition has gone
            if (ackContact && !s_r.cond[i])
                s_nxt.ackPend[i] = 1'b1;
            if (s_r.cond[i])
                s_nxt.ackPend[i] = 1'b0;
            if (fDone[i] && !s_r.configLevel)
            begin
                f = sx(filt[i]);
                sp = sx(s_r.setpoint);
                th = sx(s_r.thr[i]);
                hy = sx(s_r.hyst[i]);
                hiSense = (s_r.cfg[i].sense == pau_pkg::SNS_HIGH);
                ackEff = s_r.ackPend[i] || (ackContact && !s_r.cond[i]);
                ref0 = (s_r.cfg[i].kind == pau_pkg::TYP_PROCESS) ? th
                                                               : sp + th;
                unique case (s_r.cfg[i].kind)
                    pau_pkg::TYP_PROCESS, pau_pkg::TYP_DEVIATION:
                    begin
                        if (hiSense)
                        begin
                            setC = f > ref0;
                            clrC = f < ref0 - hy;
                        end
                        else
                        begin
                            setC = f < ref0;
                            clrC = f > ref0 + hy;
                        end
                    end
                    pau_pkg::TYP_BAND:
                    begin
                        if (hiSense)
                        begin
                            setC = (f > sp + th) || (f < sp - th);
                            clrC = (f < sp + th - hy) && (f > sp - th + hy);
                        end
                        else
                        begin
                            setC = (f > sp - th) && (f < sp + th);
                            clrC = (f > sp + th + hy) || (f < sp - th - hy);
                        end
                    end
                    pau_pkg::TYP_OFF:
                    begin
                        setC = 1'b0;
                        clrC = 1'b1;
                    end
                endcase
                if (s_r.cfg[i].kind == pau_pkg::TYP_OFF)
                begin
                    // relay deliberately left where it was
                    s_nxt.cond[i] = 1'b0;
                    s_nxt.alarm[i] = 1'b0;
                end
                else
                begin
                    s_nxt.cond[i] = s_r.cond[i] ? !clrC : setC;
                    rearm = s_r.restorePend ||
                            (s_r.cfg[i].kind != pau_pkg::TYP_PROCESS &&
                             (s_r.spChgPend || setpointRamp));
                    if (s_r.cfg[i].sense != pau_pkg::SNS_LOW_INHIBIT)
                        s_nxt.mask[i] = 1'b0;
                    else if (rearm)
                        s_nxt.mask[i] = 1'b1;
                    else if (!s_nxt.cond[i])
                        s_nxt.mask[i] = 1'b0;
                    // new activity wins over a pending release
                    s_nxt.alarm[i] = (s_nxt.cond[i] && !s_nxt.mask[i]) ||
                        (s_r.cfg[i].latching && s_r.alarm[i] &&
                         !ackEff);
                    s_nxt.relay[i] = s_r.cfg[i].polarity ?
                                     !s_nxt.alarm[i] : s_nxt.alarm[i];
                end
                s_nxt.ackPend[i] = 1'b0;
            end
        end
        if (fDone[0] && !s_r.configLevel)
        begin
            s_nxt.restorePend = regWr && (regAddr == `PAU_ADDR_CTRL) &&
                                regWdata[`PAU_CTRL_RESTORE];
            s_nxt.spChgPend = regWr && (regAddr == `PAU_ADDR_SP) &&
                              (regWdata[DW-1:0] != s_r.setpoint);
        end
        s_nxt.led = s_r.configLevel ? 3'b000 : s_r.alarm;
        s_nxt.beacon = !s_r.configLevel && (|s_r.alarm);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_r <= '0;
            for (int i = 0; i < 3; i++)
            begin
                s_r.cfg[i] <= `PAU_CFG_RST;
                s_r.thr[i] <= `PAU_THR_RST;
                s_r.hyst[i] <= `PAU_HYST_RST;
            end
            s_r.setpoint <= `PAU_SP_RST;
            s_r.mask <= 3'b111;
            s_r.relay <= 3'b111;
        end
        else
            s_r <= s_nxt;
    end

    assign regRdata    = s_r.rdata;
    assign relayDrive  = s_r.relay;
    assign alarmLed    = s_r.led;
    assign alarmBeacon = s_r.beacon;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence evalCh0;
        fDone[0] && !s_r.configLevel &&
        s_r.cfg[0].kind != pau_pkg::TYP_OFF;
    endsequence
    sequence condGone0;
        ##1 !s_r.cond[0];
    endsequence

    a_beacon_any: assert property (
        (|s_r.alarm) && !s_r.configLevel |=> alarmBeacon)
        else $error("beacon dark while an alarm is active");
    a_cfg_quiet: assert property (
        s_r.configLevel |=> !alarmBeacon && alarmLed == 3'b000)
        else $error("indication shown in configuration level");
    a_off_idle: assert property (
        fDone[0] && !s_r.configLevel &&
        s_r.cfg[0].kind == pau_pkg::TYP_OFF
        |=> !s_r.alarm[0] && $stable(relayDrive[0]))
        else $error("disabled channel alarmed or moved its relay");
    a_relay_follow: assert property (
        evalCh0 |=> relayDrive[0] ==
            ($past(s_r.cfg[0].polarity) ? !s_r.alarm[0] : s_r.alarm[0]))
        else $error("relay drive disagrees with polarity");
    a_reset_failsafe: assert property (
        $fell(srst) |-> s_r.cfg[0].polarity && s_r.cfg[1].polarity &&
                        s_r.cfg[2].polarity && relayDrive == 3'b111)
        else $error("polarity not failsafe after reset");
    a_auto_clear: assert property (
        (evalCh0 and !s_r.cfg[0].latching) ##0 condGone0 |-> !s_r.alarm[0])
        else $error("automatic alarm stayed without its condition");
    a_latch_hold: assert property (
        s_r.alarm[1] && s_r.cfg[1].latching && s_r.cond[1] &&
        !s_r.configLevel && s_r.cfg[1].kind != pau_pkg::TYP_OFF
        |=> s_r.alarm[1])
        else $error("latched alarm released while condition present");
    a_mask_restore: assert property (
        evalCh0 ##0 (s_r.restorePend &&
        s_r.cfg[0].sense == pau_pkg::SNS_LOW_INHIBIT) |=> s_r.mask[0])
        else $error("restore command did not re-arm the mask");
    a_proc_high: assert property (
        evalCh0 ##0 (s_r.cfg[0].kind == pau_pkg::TYP_PROCESS &&
        s_r.cfg[0].sense == pau_pkg::SNS_HIGH &&
        $signed(filt[0]) > $signed(s_r.thr[0])) |=> s_r.cond[0])
        else $error("process high did not set above threshold");
endmodule : pau_process_alarm_unit

// [verif/pau_plant_model.sv]
// Purpose: process value source and acknowledge contact
// Assumes: bench sets the wanted levels on ref_clk edges
// Notes:   outputs registered, so they move one cycle later
`timescale 1ns/1ps
module pau_plant_model (
    // clock
    input  wire logic        ref_clk,
    // wanted levels
    input  wire logic [15:0] pvLevel,
    input  wire logic        ackReq,
    // process side
    output logic      [15:0] processValue,
    output logic             ackContact
);
    // single driver: the first edge replaces the power-up unknowns
    always_ff @(posedge ref_clk)
    begin
        processValue <= pvLevel;
        // pushbutton closure on the acknowledge input
        ackContact <= ackReq;
    end
endmodule : pau_plant_model

// [verif/pau_process_alarm_unit_tb_top.sv]
// Purpose: self-checking bench of the process alarm unit
// Assumes: filter mostly off, short sample period of 20 cycles
// Notes:   each step waits two samples plus the output latency
`timescale 1ns/1ps
module pau_process_alarm_unit_tb_top;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0000_0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    logic [15:0] pvLevel = 16'h0000;
    logic        ackReq = 1'b0;
    logic        setpointRamp = 1'b0;
    logic [15:0] processValue;
    logic        ackContact;
    logic [2:0]  relayDrive;
    logic [2:0]  alarmLed;
    logic        alarmBeacon;
    int          n_errors = 0;
    int          n_checks = 0;
    always #4 ref_clk = ~ref_clk;
    pau_process_alarm_unit #(.SAMPLE_CYCLES(20)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .processValue(processValue),
        .setpointRamp(setpointRamp), .ackContact(ackContact),
        .relayDrive(relayDrive), .alarmLed(alarmLed),
        .alarmBeacon(alarmBeacon)
    );
    pau_plant_model plant_u (
        .ref_clk(ref_clk), .pvLevel(pvLevel), .ackReq(ackReq),
        .processValue(processValue), .ackContact(ackContact)
    );
    task conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    task rdc(input logic [3:0] a, input logic [31:0] exp,
             input logic [31:0] msk);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata & msk, exp);
    endtask : rdc
    // two full samples guarantee one evaluation saw the new value
    task step(input logic [15:0] pv, input logic [2:0] r,
              input logic [2:0] l);
        @(posedge ref_clk);
        pvLevel <= pv;
        repeat (45) @(posedge ref_clk);
        #1;
        chk({29'h0, relayDrive}, {29'h0, r});
        chk({29'h0, alarmLed}, {29'h0, l});
        chk({31'h0, alarmBeacon}, {31'h0, |l});
    endtask : step
    task ack;
        @(posedge ref_clk);
        ackReq <= 1'b1;
        repeat (5) @(posedge ref_clk);
        ackReq <= 1'b0;
    endtask : ack
    initial
    begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk({29'h0, relayDrive}, 32'h0000_0007);
        rdc(4'h4, 32'h0000_0020, 32'hFFFF_FFFF);
        rdc(4'h3, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(4'h6, 32'h0000_0001);
        rdc(4'h6, 32'h0000_0003, 32'hFFFF_FFFF);
        wr(4'h6, 32'h0000_03E8);
        rdc(4'h6, 32'h0000_012C, 32'hFFFF_FFFF);
        wr(4'h6, 32'h0000_001E);
        wr(4'h5, 32'h0000_0064);
        wr(4'h4, 32'h0000_0021);
        step(16'h0096, 3'b110, 3'b001);
        step(16'h0050, 3'b110, 3'b001);
        step(16'h003C, 3'b111, 3'b000);
        // long filter keeps a step below threshold for a while
        wr(4'h4, 32'h0000_01A1);
        step(16'h0096, 3'b111, 3'b000);
        wr(4'h4, 32'h0000_0021);
        step(16'h0096, 3'b110, 3'b001);
        step(16'h003C, 3'b111, 3'b000);
        wr(4'h4, 32'h0000_0020);
        // channel two: process low, latching, non-failsafe
        wr(4'h9, 32'h0000_0064);
        step(16'h00C8, 3'b111, 3'b000);
        wr(4'h8, 32'h0000_0015);
        step(16'h00C8, 3'b101, 3'b000);
        step(16'h0032, 3'b111, 3'b010);
        ack;
        step(16'h0032, 3'b111, 3'b010);
        step(16'h00C8, 3'b111, 3'b010);
        ack;
        step(16'h00C8, 3'b101, 3'b000);
        wr(4'h8, 32'h0000_0020);
        // channel three: deviation high around setpoint 1000
        wr(4'h1, 32'h0000_03E8);
        wr(4'hD, 32'h0000_01F4);
        wr(4'hC, 32'h0000_0023);
        step(16'h0640, 3'b001, 3'b100);
        step(16'h05E6, 3'b001, 3'b100);
        step(16'h05B4, 3'b101, 3'b000);
        // channel three: deviation low, mask re-armed by setpoint moves
        wr(4'hC, 32'h0000_002F);
        wr(4'h1, 32'h0000_03F2);
        step(16'h05B4, 3'b101, 3'b000);
        @(posedge ref_clk) setpointRamp <= 1'b1;
        step(16'h0640, 3'b101, 3'b000);
        step(16'h05B4, 3'b101, 3'b000);
        @(posedge ref_clk) setpointRamp <= 1'b0;
        step(16'h0640, 3'b101, 3'b000);
        step(16'h05B4, 3'b001, 3'b100);
        step(16'h0640, 3'b101, 3'b000);
        wr(4'h1, 32'h0000_03E8);
        wr(4'hC, 32'h0000_0020);
        // channel one: band high, window 500..1500
        wr(4'h5, 32'h0000_01F4);
        wr(4'h4, 32'h0000_0022);
        step(16'h0190, 3'b100, 3'b001);
        step(16'h0208, 3'b100, 3'b001);
        step(16'h021C, 3'b101, 3'b000);
        // channel one: process low, inhibited until first safe
        wr(4'h5, 32'h0000_0064);
        wr(4'h4, 32'h0000_002D);
        wr(4'h0, 32'h0000_0002);
        step(16'h0032, 3'b101, 3'b000);
        step(16'h00C8, 3'b101, 3'b000);
        step(16'h0032, 3'b100, 3'b001);
        rdc(4'h2, 32'h0000_0809, 32'h0000_0E3F);
        // configuration level: relays hold, no indication
        wr(4'h0, 32'h0000_0001);
        step(16'h0032, 3'b100, 3'b000);
        rdc(4'h0, 32'h0000_0001, 32'hFFFF_FFFF);
        conclude();
    end
endmodule : pau_process_alarm_unit_tb_top
